/* File: swpm_consts.svh */
`ifndef SWPM_CONSTS_SVH
`define SWPM_CONSTS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define SWPM_ADDR_MODE      8'h00
`define SWPM_ADDR_SLEEP     8'h04
`define SWPM_ADDR_STAT      8'h08
`define SWPM_ADDR_PORT0     8'h10
`define SWPM_ADDR_PHY0      8'h30
`define SWPM_NPORT          5

// ****************************************
// Field positions and reset values
// ****************************************
`define SWPM_MODE_LSB       3
`define SWPM_PORT_PD_BIT    3
`define SWPM_PHY_PD_BIT     11
`define SWPM_PHY_AN_BIT     12
`define SWPM_MODE_RST       2'h0
`define SWPM_SLEEP_RST      8'h10
`define SWPM_PHY_AN_RST     1'h1

// ****************************************
// Timing
// ****************************************
`define SWPM_CLK_MHZ        100
`define SWPM_PULSE_NS       120
`define SWPM_PULSE_CYC      ((`SWPM_PULSE_NS * `SWPM_CLK_MHZ + 999) / 1000)
`define SWPM_PULSE_MS       1000
`define SWPM_PERIOD_CYC     (`SWPM_PULSE_MS * `SWPM_CLK_MHZ * 1000)
`define SWPM_SLEEP_UNIT_US  1000
`define SWPM_SLEEP_UNIT_CYC (`SWPM_SLEEP_UNIT_US * `SWPM_CLK_MHZ)
`define SWPM_IRST_CYC       16

`endif

/* File: swpm_pkg.sv */
package swpm_pkg;

	typedef enum logic [1:0] {
		SWPM_MODE_NORMAL,
		SWPM_MODE_ENERGY,
		SWPM_MODE_SOFT_PD,
		SWPM_MODE_SAVING
	} swpm_mode_e;

	typedef enum {
		SWPM_ST_NORMAL,
		SWPM_ST_ED_AWAKE,
		SWPM_ST_ED_SLEEP,
		SWPM_ST_SOFT_PD,
		SWPM_ST_SAVING,
		SWPM_ST_HW_PD,
		SWPM_ST_IRST
	} swpm_state_e;

endpackage

/* File: swpm_pulse_if.sv */
`timescale 1ns/100ps

interface swpm_pulse_if;
	logic run;
	logic pulse;

	modport gen (input run, output pulse);
	modport user (output run, input pulse);
endinterface

/* File: swpm_pulse_gen.sv */
`timescale 1ns/100ps
`include "swpm_consts.svh"

module swpm_pulse_gen #(
	parameter int PERIOD_CYC = `SWPM_PERIOD_CYC
) (
	input wire logic     clk,    // System clock
	input wire logic     rst_n,  // Asynchronous reset, active low
	swpm_pulse_if.gen    pif     // Run request and pulse out
);
	logic [31:0] cnt_r;
	logic        pulse_r;

	assign pif.pulse = pulse_r;

	// ****************************************
	// Period counter, restarts whenever idle
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 32'h0;
		end else if (!pif.run || cnt_r == 32'(PERIOD_CYC - 1)) begin
			cnt_r <= 32'h0;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end

	// One pulse of fixed width at the start of each period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_r <= 1'b0;
		end else begin
			pulse_r <= pif.run && (cnt_r < 32'(`SWPM_PULSE_CYC));
		end
	end
endmodule

/* File: swpm_top.sv */
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "swpm_consts.svh"

module swpm_top
	import swpm_pkg::*;
#(
	parameter int PERIOD_CYC     = `SWPM_PERIOD_CYC,
	parameter int SLEEP_UNIT_CYC = `SWPM_SLEEP_UNIT_CYC
) (
	input  wire logic        CLOCK,              // 100 MHz system clock
	input  wire logic        RST_N,              // Asynchronous reset, active low
	input  wire logic        CHIP_POWER_DOWN_N,  // Hardware power-down pin, active low
	input  wire logic [4:0]  ENERGY,             // Per-port cable energy seen, pins
	input  wire logic        CYC_I,              // Wishbone cycle
	input  wire logic        STB_I,              // Wishbone strobe
	input  wire logic        WE_I,               // Wishbone write enable
	input  wire logic [7:0]  ADR_I,              // Wishbone byte address
	input  wire logic [3:0]  SEL_I,              // Wishbone byte selects
	input  wire logic [31:0] DAT_I,              // Wishbone write data
	output logic      [31:0] DAT_O,              // Wishbone read data
	output logic             ACK_O,              // Wishbone acknowledge
	output logic             PLL_EN,             // PLL clocks enabled
	output logic             MAC_EN,             // MACs enabled
	output logic             HOST_EN,            // Host interface enabled
	output logic      [4:0]  PHY_TX_EN,          // Per-port PHY transmitter on
	output logic      [4:0]  PHY_RX_EN,          // Per-port PHY receiver on
	output logic      [4:0]  PHY_ED_EN,          // Per-port energy detector on
	output logic      [4:0]  TX_PULSE,           // Per-port link pulse
	output logic             INT_RST_N           // Internal reset, active low
);
	// ****************************************
	// Declarations
	// ****************************************
	swpm_state_e state_r, state_nxt;
	logic [1:0]  mode_r;
	logic [7:0]  sleep_r;
	logic [4:0]  port_pd_r;
	logic [4:0]  phy_pd_r;
	logic [4:0]  an_en_r;
	logic        pd_meta_r, pd_sync_r;
	logic [4:0]  en_meta_r, en_sync_r;
	logic        ack_r;
	logic [31:0] rdat_r;
	logic [4:0]  irst_cnt_r;
	logic [31:0] unit_cnt_r;
	logic [8:0]  sleep_cnt_r;
	logic        any_energy;
	logic        access;
	logic        blocked;
	logic        wr_ok;
	logic        cfg_clr;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [4:0]  port_off;
	swpm_pulse_if pif ();

	// Byte-lane mask from Wishbone selects
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// Returns port index+1 when addr hits the bank at base, else 0
	function automatic logic [2:0] bank_hit(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] off;
		off = addr - base;
		bank_hit = 3'h0;
		if (off[1:0] == 2'h0 && off[7:2] < 6'(`SWPM_NPORT))
			bank_hit = 3'(off[4:2]) + 3'h1;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			pd_meta_r <= 1'b1;
			pd_sync_r <= 1'b1;
			en_meta_r <= 5'h0;
			en_sync_r <= 5'h0;
		end else begin
			pd_meta_r <= CHIP_POWER_DOWN_N;
			pd_sync_r <= pd_meta_r;
			en_meta_r <= ENERGY;
			en_sync_r <= en_meta_r;
		end
	end

	assign any_energy = |en_sync_r;

	// ****************************************
	// Wishbone slave
	// ****************************************
	assign access = CYC_I && STB_I;
	// Off or resetting: access is answered, reads return zero and writes are ignored
	assign blocked = state_r == SWPM_ST_SOFT_PD || state_r == SWPM_ST_HW_PD ||
	                 state_r == SWPM_ST_IRST;
	assign wr_ok = access && WE_I && !ack_r && !blocked;
	assign wmask = lane_mask(SEL_I);
	assign wval  = DAT_I & wmask;
	assign cfg_clr = state_r == SWPM_ST_HW_PD || state_r == SWPM_ST_IRST;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= access && !ack_r;
		end
	end

	assign ACK_O = ack_r;
	assign DAT_O = rdat_r;
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rdat_r <= 32'h0;
		end else if (access && !ack_r && !WE_I && !blocked) begin
			rdat_r <= 32'h0;
			if (ADR_I == `SWPM_ADDR_MODE)
				rdat_r[`SWPM_MODE_LSB +: 2] <= mode_r;
			else if (ADR_I == `SWPM_ADDR_SLEEP)
				rdat_r[7:0] <= sleep_r;
			else if (ADR_I == `SWPM_ADDR_STAT)
				rdat_r <= {11'h0, PHY_RX_EN, 3'h0, PHY_TX_EN,
				           4'h0, state_r == SWPM_ST_ED_SLEEP, HOST_EN, MAC_EN, PLL_EN};
			else if (bank_hit(ADR_I, `SWPM_ADDR_PORT0) != 3'h0)
				rdat_r[`SWPM_PORT_PD_BIT] <= port_pd_r[bank_hit(ADR_I, `SWPM_ADDR_PORT0) - 3'h1];
			else if (bank_hit(ADR_I, `SWPM_ADDR_PHY0) != 3'h0) begin
				rdat_r[`SWPM_PHY_PD_BIT] <= phy_pd_r[bank_hit(ADR_I, `SWPM_ADDR_PHY0) - 3'h1];
				rdat_r[`SWPM_PHY_AN_BIT] <= an_en_r[bank_hit(ADR_I, `SWPM_ADDR_PHY0) - 3'h1];
			end
		end else if (access && !ack_r) begin
			rdat_r <= 32'h0;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			mode_r  <= `SWPM_MODE_RST;
			sleep_r <= `SWPM_SLEEP_RST;
		end else if (cfg_clr) begin
			mode_r  <= `SWPM_MODE_RST;
			sleep_r <= `SWPM_SLEEP_RST;
		end else if (wr_ok && ADR_I == `SWPM_ADDR_MODE && SEL_I[0]) begin
			mode_r <= wval[`SWPM_MODE_LSB +: 2];
		end else if (wr_ok && ADR_I == `SWPM_ADDR_SLEEP && SEL_I[0]) begin
			sleep_r <= wval[7:0];
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			port_pd_r <= 5'h0;
			phy_pd_r  <= 5'h0;
			an_en_r   <= {5{`SWPM_PHY_AN_RST}};
		end else if (cfg_clr) begin
			port_pd_r <= 5'h0;
			phy_pd_r  <= 5'h0;
			an_en_r   <= {5{`SWPM_PHY_AN_RST}};
		end else if (wr_ok) begin
			for (int i = 0; i < `SWPM_NPORT; i++) begin
				if (bank_hit(ADR_I, `SWPM_ADDR_PORT0) == 3'(i + 1) && SEL_I[0])
					port_pd_r[i] <= wval[`SWPM_PORT_PD_BIT];
				if (bank_hit(ADR_I, `SWPM_ADDR_PHY0) == 3'(i + 1) && SEL_I[1]) begin
					phy_pd_r[i] <= wval[`SWPM_PHY_PD_BIT];
					an_en_r[i]  <= wval[`SWPM_PHY_AN_BIT];
				end
			end
		end
	end

	// ****************************************
	// Power state machine
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SWPM_ST_HW_PD: begin
				if (pd_sync_r)
					state_nxt = SWPM_ST_IRST;
			end
			SWPM_ST_IRST: begin
				if (irst_cnt_r == 5'(`SWPM_IRST_CYC - 1))
					state_nxt = SWPM_ST_NORMAL;
			end
			SWPM_ST_SOFT_PD: begin
				if (access)
					state_nxt = SWPM_ST_IRST;
			end
			SWPM_ST_ED_SLEEP: begin
				if (any_energy || mode_r != SWPM_MODE_ENERGY)
					state_nxt = SWPM_ST_ED_AWAKE;
			end
			SWPM_ST_ED_AWAKE: begin
				if (mode_r != SWPM_MODE_ENERGY)
					state_nxt = SWPM_ST_NORMAL;
				else if (sleep_cnt_r > {1'b0, sleep_r})
					state_nxt = SWPM_ST_ED_SLEEP;
			end
			SWPM_ST_NORMAL, SWPM_ST_SAVING: begin
				case (mode_r)
					SWPM_MODE_ENERGY:  state_nxt = SWPM_ST_ED_AWAKE;
					SWPM_MODE_SOFT_PD: state_nxt = SWPM_ST_SOFT_PD;
					SWPM_MODE_SAVING:  state_nxt = SWPM_ST_SAVING;
					default:           state_nxt = SWPM_ST_NORMAL;
				endcase
			end
			default: state_nxt = SWPM_ST_IRST;
		endcase
		if (!pd_sync_r)
			state_nxt = SWPM_ST_HW_PD;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= SWPM_ST_NORMAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			irst_cnt_r <= 5'h0;
		end else begin
			irst_cnt_r <= (state_r == SWPM_ST_IRST) ? irst_cnt_r + 5'h1 : 5'h0;
		end
	end

	// Idle time counted in units so the 8-bit delay spans useful times
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			unit_cnt_r  <= 32'h0;
			sleep_cnt_r <= 9'h0;
		end else if (state_r != SWPM_ST_ED_AWAKE || any_energy) begin
			unit_cnt_r  <= 32'h0;
			sleep_cnt_r <= 9'h0;
		end else if (unit_cnt_r == 32'(SLEEP_UNIT_CYC - 1)) begin
			unit_cnt_r <= 32'h0;
			if (sleep_cnt_r != 9'h1FF)
				sleep_cnt_r <= sleep_cnt_r + 9'h1;
		end else begin
			unit_cnt_r <= unit_cnt_r + 32'h1;
		end
	end

	// ****************************************
	// Link pulse generator
	// ****************************************
	assign pif.run = state_r == SWPM_ST_ED_AWAKE || state_r == SWPM_ST_ED_SLEEP;

	swpm_pulse_gen #(
		.PERIOD_CYC (PERIOD_CYC)
	) u_pulse (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.pif   (pif)
	);

	// ****************************************
	// Block enables
	// ****************************************
	assign port_off = port_pd_r | phy_pd_r;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			PLL_EN    <= 1'b0;
			MAC_EN    <= 1'b0;
			HOST_EN   <= 1'b0;
			INT_RST_N <= 1'b0;
		end else begin
			case (state_r)
				SWPM_ST_NORMAL, SWPM_ST_SAVING, SWPM_ST_ED_AWAKE: begin
					PLL_EN  <= 1'b1;
					MAC_EN  <= 1'b1;
					HOST_EN <= 1'b1;
				end
				default: begin
					PLL_EN  <= 1'b0;
					MAC_EN  <= 1'b0;
					HOST_EN <= 1'b0;
				end
			endcase
			INT_RST_N <= state_r != SWPM_ST_HW_PD && state_r != SWPM_ST_IRST;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			PHY_TX_EN <= 5'h0;
			PHY_RX_EN <= 5'h0;
			PHY_ED_EN <= 5'h0;
			TX_PULSE  <= 5'h0;
		end else begin
			PHY_TX_EN <= 5'h0;
			PHY_RX_EN <= 5'h0;
			PHY_ED_EN <= 5'h0;
			TX_PULSE  <= 5'h0;
			case (state_r)
				SWPM_ST_NORMAL, SWPM_ST_ED_AWAKE: begin
					PHY_TX_EN <= ~port_off;
					PHY_RX_EN <= ~port_off;
				end
				SWPM_ST_SAVING: begin
					PHY_TX_EN <= ~port_off;
					// Receiver also off, besides port power-down, with autoneg on and no line energy
					PHY_RX_EN <= ~port_off & ~(an_en_r & ~en_sync_r);
				end
				SWPM_ST_ED_SLEEP: begin
					PHY_ED_EN <= ~port_off;
				end
				default: PHY_TX_EN <= 5'h0;
			endcase
			if (pif.run)
				TX_PULSE <= {5{pif.pulse}} & ~en_sync_r & ~port_off;
		end
	end
endmodule

/* File: swpm_top_chk.sv */
`timescale 1ns/100ps

module swpm_top_chk (
	input wire logic       CLOCK,             // System clock
	input wire logic       RST_N,             // Reset, active low
	input wire logic       CHIP_POWER_DOWN_N, // Power-down pin
	input wire logic [4:0] ENERGY,            // Cable energy
	input wire logic       CYC_I,             // Bus cycle
	input wire logic       STB_I,             // Bus strobe
	input wire logic       ACK_O,             // Bus acknowledge
	input wire logic       PLL_EN,            // Clocks on
	input wire logic       MAC_EN,            // MACs on
	input wire logic       HOST_EN,           // Host side on
	input wire logic [4:0] PHY_TX_EN,         // Transmitters on
	input wire logic [4:0] PHY_RX_EN,         // Receivers on
	input wire logic [4:0] PHY_ED_EN,         // Energy detectors on
	input wire logic [4:0] TX_PULSE,          // Link pulses
	input wire logic       INT_RST_N          // Internal reset
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	a_pin_off: assert property (
		!CHIP_POWER_DOWN_N [*6] |-> !PLL_EN && !MAC_EN && !HOST_EN && !INT_RST_N &&
		PHY_ED_EN == 5'h00)
		else $error("power-down pin left the chip running");
	a_pin_reset: assert property (
		$rose(CHIP_POWER_DOWN_N) |-> !INT_RST_N [*8])
		else $error("no internal reset after pin release");
	a_normal_on: assert property (
		$rose(INT_RST_N) |-> ##[0:2] (PLL_EN && MAC_EN && HOST_EN))
		else $error("normal operation not restored");
	a_ack_next: assert property (
		CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("bus request not answered next cycle");
	a_clk_off: assert property (
		!PLL_EN |-> !MAC_EN && !HOST_EN && PHY_TX_EN == 5'h00 && PHY_RX_EN == 5'h00)
		else $error("MAC or host side on without clocks");
	a_save_alive: assert property (
		(PHY_TX_EN & ~PHY_RX_EN) != 5'h00 |-> PLL_EN && MAC_EN && HOST_EN)
		else $error("receiver-only shutdown lost clocks or MAC");
	a_rx_back: assert property (
		$rose(ENERGY[2]) && PHY_TX_EN[2] && !PHY_RX_EN[2] && PLL_EN
		|-> ##[1:6] PHY_RX_EN[2])
		else $error("receiver not restored on line activity");
	a_ed_wake: assert property (
		$rose(ENERGY[0]) && !PLL_EN && PHY_ED_EN[0] |-> ##[1:6] PLL_EN)
		else $error("no wake from sleep on energy");
	a_pulse_len: assert property (
		$rose(TX_PULSE[0]) |-> TX_PULSE[0] [*8] ##1 TX_PULSE[0] [*4] ##1 !TX_PULSE[0])
		else $error("link pulse width wrong");
endmodule

bind swpm_top swpm_top_chk u_chk (
	.CLOCK(CLOCK), .RST_N(RST_N), .CHIP_POWER_DOWN_N(CHIP_POWER_DOWN_N),
	.ENERGY(ENERGY), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
	.PLL_EN(PLL_EN), .MAC_EN(MAC_EN), .HOST_EN(HOST_EN), .PHY_TX_EN(PHY_TX_EN),
	.PHY_RX_EN(PHY_RX_EN), .PHY_ED_EN(PHY_ED_EN), .TX_PULSE(TX_PULSE),
	.INT_RST_N(INT_RST_N)
);

/* File: swpm_host.sv */
`timescale 1ns/100ps

module swpm_host (
	input  wire logic        clk, // Bus clock
	output logic             cyc, // Cycle
	output logic             stb, // Strobe
	output logic             we,  // Write enable
	output logic      [7:0]  adr, // Byte address
	output logic      [3:0]  sel, // Byte selects
	output logic      [31:0] dwr, // Write data
	input  wire logic [31:0] drd, // Read data
	input  wire logic        ack  // Acknowledge
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dwr = 32'h0;
	end

	// Called just after a rising edge; holds everything until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dwr <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = drd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
endmodule

/* File: swpm_top_tb.sv */
`timescale 1ns/100ps
`include "swpm_consts.svh"

module swpm_top_tb;
	logic        clk, rst_n, pd_n, cyc, stb, we, ack, pll, mac, hst, irst_n;
	logic [4:0]  energy, txe, rxe, ede, pls;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dwr, drd, q;
	int          failures, check_count, n;

	swpm_top #(.PERIOD_CYC(200), .SLEEP_UNIT_CYC(4)) DUT (.CLOCK(clk), .RST_N(rst_n),
		.CHIP_POWER_DOWN_N(pd_n), .ENERGY(energy), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(dwr), .DAT_O(drd), .ACK_O(ack), .PLL_EN(pll),
		.MAC_EN(mac), .HOST_EN(hst), .PHY_TX_EN(txe), .PHY_RX_EN(rxe), .PHY_ED_EN(ede),
		.TX_PULSE(pls), .INT_RST_N(irst_n));
	swpm_host u_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dwr(dwr), .drd(drd), .ack(ack));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		u_host.xfer(1'b1, a, s, d, q);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		u_host.xfer(1'b0, a, 4'hF, 32'h0, q);
		chk(nm, q, e);
	endtask
	task automatic summarize;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rdc("mode", `SWPM_ADDR_MODE, 32'h0);
		rdc("sleep", `SWPM_ADDR_SLEEP, 32'h10);
		rdc("unmapped", 8'hFC, 32'h0);
		chk("normal", {pll, mac, hst, irst_n, txe, rxe}, 14'h3FFF);
		$display("done reset");
	endtask
	task automatic t_port;
		wr(`SWPM_ADDR_PORT0 + 8'h04, 4'h1, 32'h8);
		repeat (4) @(posedge clk);
		chk("port pd", {txe, rxe}, 10'h3BD);
		wr(`SWPM_ADDR_PORT0 + 8'h04, 4'h1, 32'h0);
		wr(`SWPM_ADDR_PHY0 + 8'h0C, 4'h2, 32'h1800);
		repeat (4) @(posedge clk);
		chk("phy pd", {txe, rxe}, 10'h2F7);
		wr(`SWPM_ADDR_PHY0 + 8'h0C, 4'h2, 32'h1000);
		wr(`SWPM_ADDR_PHY0 + 8'h0C, 4'h1, 32'h800);
		rdc("sel lane", `SWPM_ADDR_PHY0 + 8'h0C, 32'h1000);
		$display("done port");
	endtask
	task automatic t_save;
		wr(`SWPM_ADDR_PHY0, 4'h2, 32'h0);
		wr(`SWPM_ADDR_MODE, 4'h1, 32'h18);
		repeat (4) @(posedge clk);
		chk("saving", {pll, mac, hst, txe, rxe}, 13'h1FE1);
		rdc("mode kept", `SWPM_ADDR_MODE, 32'h18);
		rdc("stat", `SWPM_ADDR_STAT, 32'h00011F07);
		energy <= 5'h04;
		repeat (6) @(posedge clk);
		chk("rx back", rxe, 5'h05);
		energy <= 5'h00;
		wr(`SWPM_ADDR_PHY0, 4'h2, 32'h1000);
		wr(`SWPM_ADDR_MODE, 4'h1, 32'h0);
		repeat (4) @(posedge clk);
		chk("save exit", rxe, 5'h1F);
		$display("done save");
	endtask
	task automatic t_energy;
		wr(`SWPM_ADDR_SLEEP, 4'h1, 32'h2);
		wr(`SWPM_ADDR_MODE, 4'h1, 32'h08);
		for (n = 0; n < 200 && pll !== 1'b0; n++) @(posedge clk);
		chk("sleep delay", 32'(n > 8 && n < 24), 32'h1);
		chk("ed sleep", {mac, hst, ede, rxe}, 12'h3E0);
		rdc("stat sleep", `SWPM_ADDR_STAT, 32'h8);
		for (n = 0; n < 300 && pls[0] !== 1'b1; n++) @(posedge clk);
		for (n = 0; n < 50 && pls[0] === 1'b1; n++) @(posedge clk);
		chk("pulse", n, `SWPM_PULSE_CYC);
		energy <= 5'h01;
		for (n = 0; n < 10 && pll !== 1'b1; n++) @(posedge clk);
		@(posedge clk);
		chk("ed wake", {pll, rxe[0]}, 2'h3);
		wr(`SWPM_ADDR_MODE, 4'h1, 32'h0);
		energy <= 5'h00;
		$display("done energy");
	endtask
	task automatic t_soft;
		wr(`SWPM_ADDR_SLEEP, 4'h1, 32'h5);
		wr(`SWPM_ADDR_MODE, 4'h1, 32'h10);
		repeat (4) @(posedge clk);
		chk("soft pd", {pll, mac, txe, rxe}, 12'h0);
		rdc("wake read", `SWPM_ADDR_SLEEP, 32'h0);
		chk("wake rst", irst_n, 1'b0);
		for (n = 0; n < 40 && irst_n !== 1'b1; n++) @(posedge clk);
		rdc("sleep dflt", `SWPM_ADDR_SLEEP, 32'h10);
		rdc("mode dflt", `SWPM_ADDR_MODE, 32'h0);
		$display("done soft");
	endtask
	task automatic t_hwpd;
		pd_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("hw pd", {pll, mac, hst, irst_n, txe}, 9'h0);
		pd_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("hw rst", irst_n, 1'b0);
		for (n = 0; n < 40 && irst_n !== 1'b1; n++) @(posedge clk);
		@(posedge clk);
		chk("hw back", {pll, mac, hst}, 3'h7);
		$display("done hwpd");
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run is about 360 cycles; this bound only cuts a hang
	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		summarize();
	end
	initial begin
		rst_n = 1'b0;
		pd_n = 1'b1;
		energy = 5'h00;
		failures = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_port();
		t_save();
		t_energy();
		t_soft();
		t_hwpd();
		summarize();
	end
endmodule
